// File: rtl/clkgen_pkg.sv
// constants shared by the processor clock, ready and reset generator
// assumes one 100 MHz system clock; all pins arrive asynchronously
package clkgen_pkg;

  // ==========================================================
  // pin synchroniser vector layout
  localparam int PIN_COUNT   = 10;       // pins passed through two flops
  localparam int PIN_XTAL    = 0;        // crystal_a level
  localparam int PIN_EFI     = 1;        // ext_freq_in level
  localparam int PIN_CLEAR   = 2;        // divider_clear
  localparam int PIN_SRCSEL  = 3;        // source_select strap
  localparam int PIN_DEPTH   = 4;        // sync_depth_select
  localparam int PIN_DONE1   = 5;        // bus1_done_in
  localparam int PIN_QUAL1N  = 6;        // bus1_qualifier_n
  localparam int PIN_DONE2   = 7;        // bus2_done_in
  localparam int PIN_QUAL2N  = 8;        // bus2_qualifier_n
  localparam int PIN_PORN    = 9;        // power_on_request_n

  // reset image of both synchroniser stages: qualifiers idle high,
  // depth select high (single stage), reset request asserted (low)
  localparam logic [PIN_COUNT-1:0] PIN_RST = 10'h150;

  // ==========================================================
  // divide-by-three phases, high phase is the first of three
  typedef enum logic [1:0] {
    PH_HIGH,
    PH_LOW1,
    PH_LOW2
  } phase_t;

  // cleared state: the next source edge starts a high phase
  localparam phase_t PH_CLEARED = PH_LOW2;

  // ==========================================================
  // output reset values
  localparam logic CPU_CLK_RST   = 1'b0;   // processor clock low
  localparam logic PCLK_RST      = 1'b0;   // peripheral clock low
  localparam logic RESET_OUT_RST = 1'b1;   // processor held in reset
  localparam logic READY_RST     = 1'b0;   // not ready
  // sampled source and oscillator copy start low, so no false edge
  localparam logic LEVEL_RST     = 1'b0;

endpackage : clkgen_pkg

// File: rtl/div_if.sv
// carrier between the top and the divide-by-three clock divider
// assumes all members are on clk_i and already synchronised
`timescale 1ns/1ps
`default_nettype none
interface div_if;
  logic ce;          // clock enable, freezes the divider
  logic tick;        // one-cycle pulse per selected source rising edge
  logic clear;       // synchronised divider_clear level
  logic cpu_clk;     // processor clock level
  logic periph_clk;  // peripheral clock level
  logic cpu_rise;    // processor clock about to rise this cycle
  logic cpu_fall;    // processor clock about to fall this cycle

  // ==========================================================
  // the divider drives the clocks, the top drives its inputs
  modport divider (
    input  ce,
    input  tick,
    input  clear,
    output cpu_clk,
    output periph_clk,
    output cpu_rise,
    output cpu_fall
  );
  modport user (
    output ce,
    output tick,
    output clear,
    input  cpu_clk,
    input  periph_clk,
    input  cpu_rise,
    input  cpu_fall
  );
endinterface : div_if
`default_nettype wire

// File: rtl/cpu_clk_divider.sv
// divide-by-three processor clock and half-rate peripheral clock
// assumes tick is a one-cycle pulse per source edge on clk_i
`timescale 1ns/1ps
`default_nettype none
module cpu_clk_divider (
  input  wire logic clk_i,   // system clock
  input  wire logic srst_i,  // synchronous reset, active high
  div_if.divider    dv       // ticks in, clocks out
);
  import clkgen_pkg::*;

  // ==========================================================
  // divider state
  phase_t phase_reg;        // position within the three ticks
  phase_t phase_next;
  logic   cpu_clk_reg;      // processor clock output
  logic   cpu_clk_next;
  logic   pclk_reg;         // peripheral clock output
  logic   pclk_next;

  // next state of counter, clocks and toggle flop
  always_comb begin
    phase_next = phase_reg;
    if (dv.clear) begin
      phase_next = PH_CLEARED;         // held while clear is high
    end else if (dv.tick) begin
      case (phase_reg)                 // resumes from cleared
        PH_HIGH: phase_next = PH_LOW1;
        PH_LOW1: phase_next = PH_LOW2;
        PH_LOW2: phase_next = PH_HIGH;
        default: phase_next = PH_CLEARED;
      endcase
    end
    // high for one of three source periods
    cpu_clk_next = (phase_next == PH_HIGH) && !dv.clear;
    pclk_next    = pclk_reg;
    if (dv.clear) begin
      pclk_next = PCLK_RST;            // clear also resets it
    end else if (!cpu_clk_reg && cpu_clk_next) begin
      pclk_next = !pclk_reg;           // one toggle per cpu period
    end
  end

  // registers only; clock enable low freezes everything
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      phase_reg   <= PH_CLEARED;
      cpu_clk_reg <= CPU_CLK_RST;
      pclk_reg    <= PCLK_RST;
    end else if (dv.ce) begin
      phase_reg   <= phase_next;
      cpu_clk_reg <= cpu_clk_next;
      pclk_reg    <= pclk_next;
    end
  end

  // edge strobes are combinational so the top acts on the same edge
  assign dv.cpu_clk    = cpu_clk_reg;
  assign dv.periph_clk = pclk_reg;
  assign dv.cpu_rise   = dv.ce && !cpu_clk_reg && cpu_clk_next;
  assign dv.cpu_fall   = dv.ce && cpu_clk_reg && !cpu_clk_next;

  // ==========================================================
  // assertions
  property p_clear_holds;
    @(posedge clk_i) disable iff (srst_i)
    (dv.ce && dv.clear) |=> (!cpu_clk_reg && !pclk_reg);
  endproperty
  a_clear_holds: assert property (p_clear_holds)
    else $error("clocks not held low while divider clear");

  property p_high_one_tick;
    @(posedge clk_i) disable iff (srst_i)
    (dv.ce && cpu_clk_reg && dv.tick) |=> !cpu_clk_reg;
  endproperty
  a_high_one_tick: assert property (p_high_one_tick)
    else $error("processor clock high longer than one source period");

  property p_resume;
    @(posedge clk_i) disable iff (srst_i)
    (dv.ce && !dv.clear && dv.tick && phase_reg == PH_CLEARED)
      |=> cpu_clk_reg;
  endproperty
  a_resume: assert property (p_resume)
    else $error("divider did not resume from cleared state");

  property p_pclk_toggle;
    @(posedge clk_i) disable iff (srst_i)
    (dv.cpu_rise && !dv.clear) |=> (pclk_reg != $past(pclk_reg));
  endproperty
  a_pclk_toggle: assert property (p_pclk_toggle)
    else $error("peripheral clock did not toggle on cpu rise");

  property p_pclk_steady;
    @(posedge clk_i) disable iff (srst_i)
    (dv.ce && !dv.clear && !dv.cpu_rise) |=> $stable(pclk_reg);
  endproperty
  a_pclk_steady: assert property (p_pclk_steady)
    else $error("peripheral clock changed away from a cpu rise");

  c_pclk_high: cover property (@(posedge clk_i) disable iff (srst_i)
    $rose(pclk_reg));
endmodule : cpu_clk_divider
`default_nettype wire

// File: rtl/cpu_clock_ready_reset_gen.sv
// processor clock, ready synchroniser and reset generator
// assumes every pin input is asynchronous to clk_i; the crystal is
// modelled as a sampled level driven back through an inverter
`timescale 1ns/1ps
`default_nettype none

// Function
// - strap low selects crystal oscillator source
// - strap high selects external frequency input
// - cpu clock is input over three, one-third high
// - peripheral clock half cpu rate, 50% duty
// - oscillator output mirrors crystal frequency
// - divider clear holds counters reset
// - counters resume from cleared state on release
// - each ready valid only with low qualifier
// - depth select low gives two stages
// - depth select high gives one stage
// - ready output is synchronised ready, held
// - reset output high while request low
// - reset registered on cpu clock falling edge
// - rising ready rise-then-fall, falling ready direct
// - single stage captures only at falling edge
module cpu_clock_ready_reset_gen (
  input  wire logic clk_i,               // system clock, 100 MHz
  input  wire logic srst_i,              // synchronous reset, active high
  input  wire logic ce_i,                // clock enable, freezes state
  input  wire logic source_select_i,     // strap: 1 external, 0 crystal
  input  wire logic crystal_a_i,         // crystal amplifier input
  output logic      crystal_b_o,         // crystal amplifier output
  input  wire logic ext_freq_in_i,       // external frequency input
  input  wire logic divider_clear_i,     // divider clear, active high
  input  wire logic bus1_done_in_i,      // bus one ready, active high
  input  wire logic bus1_qualifier_n_i,  // bus one qualifier, active low
  input  wire logic bus2_done_in_i,      // bus two ready, active high
  input  wire logic bus2_qualifier_n_i,  // bus two qualifier, active low
  input  wire logic sync_depth_select_i, // 0 two stages, 1 one stage
  input  wire logic power_on_request_n_i,// reset request, active low
  output logic      cpu_clk_o,           // processor clock
  output logic      peripheral_clock_o,  // half-rate peripheral clock
  output logic      crystal_freq_out_o,  // buffered oscillator
  output logic      ready_o,             // synchronised ready
  output logic      cpu_reset_o          // processor reset, active high
);
  import clkgen_pkg::*;

  // qualifier is active low, so a high qualifier masks the input
  function automatic logic qualified(input logic done, input logic qual_n);
    qualified = done && !qual_n;
  endfunction : qualified

  // ==========================================================
  // pin synchronisers, two flops on every asynchronous input
  logic [PIN_COUNT-1:0] pins;            // raw pin vector
  logic [PIN_COUNT-1:0] meta_reg;        // first stage, read only by next
  logic [PIN_COUNT-1:0] sync_reg;        // second stage, safe to use
  logic [PIN_COUNT-1:0] meta_next;
  logic [PIN_COUNT-1:0] sync_next;

  always_comb begin
    pins              = '0;
    pins[PIN_XTAL]    = crystal_a_i;
    pins[PIN_EFI]     = ext_freq_in_i;
    pins[PIN_CLEAR]   = divider_clear_i;
    pins[PIN_SRCSEL]  = source_select_i;
    pins[PIN_DEPTH]   = sync_depth_select_i;
    pins[PIN_DONE1]   = bus1_done_in_i;
    pins[PIN_QUAL1N]  = bus1_qualifier_n_i;
    pins[PIN_DONE2]   = bus2_done_in_i;
    pins[PIN_QUAL2N]  = bus2_qualifier_n_i;
    pins[PIN_PORN]    = power_on_request_n_i;
  end

  // one identical two-flop chain per pin
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_sync
      always_comb begin
        meta_next[g] = pins[g];
        sync_next[g] = meta_reg[g];
      end
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          meta_reg[g] <= PIN_RST[g];
          sync_reg[g] <= PIN_RST[g];
        end else if (ce_i) begin
          meta_reg[g] <= meta_next[g];
          sync_reg[g] <= sync_next[g];
        end
      end
    end
  endgenerate

  // ==========================================================
  // source selection and edge detection
  logic src_level;      // selected source after synchronisers
  logic src_prev_reg;   // source one cycle ago
  logic src_prev_next;
  logic osc_reg;        // oscillator level for the buffered output
  logic osc_next;

  always_comb begin
    // crystal when strap low, external input when high
    src_level     = sync_reg[PIN_SRCSEL] ? sync_reg[PIN_EFI]
                                         : sync_reg[PIN_XTAL];
    src_prev_next = src_level;
    osc_next      = sync_reg[PIN_XTAL];  // runs even when unused
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      src_prev_reg <= LEVEL_RST;
      osc_reg      <= LEVEL_RST;
    end else if (ce_i) begin
      src_prev_reg <= src_prev_next;
      osc_reg      <= osc_next;
    end
  end

  // ==========================================================
  // divider instance
  div_if dv ();

  // the source must not exceed a quarter of clk_i to be seen cleanly
  assign dv.ce    = ce_i;
  assign dv.tick  = ce_i && src_level && !src_prev_reg;
  assign dv.clear = sync_reg[PIN_CLEAR];   // already aligned by the user

  cpu_clk_divider u_div (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .dv     (dv.divider)
  );

  // ==========================================================
  // ready synchroniser and reset flop
  logic ready_req;       // combined qualified ready request
  logic ready1_reg;      // first ready flop, rising cpu edge
  logic ready1_next;
  logic ready2_reg;      // second ready flop, falling cpu edge
  logic ready2_next;
  logic reset_reg;       // processor reset flop
  logic reset_next;

  always_comb begin
    // either bus, each gated by its own qualifier
    ready_req   = qualified(sync_reg[PIN_DONE1], sync_reg[PIN_QUAL1N]) ||
                  qualified(sync_reg[PIN_DONE2], sync_reg[PIN_QUAL2N]);
    ready1_next = ready1_reg;
    ready2_next = ready2_reg;
    reset_next  = reset_reg;
    if (dv.cpu_rise) begin
      ready1_next = ready_req;             // first stage
    end
    if (dv.cpu_fall) begin
      if (sync_reg[PIN_DEPTH]) begin
        // bypass first flop
        ready2_next = ready_req;
      end else begin
        // rising needs both stages, falling goes direct
        ready2_next = ready1_reg && ready_req;
      end
      // reset follows the request only at falling edges
      reset_next = !sync_reg[PIN_PORN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ready1_reg <= READY_RST;
      ready2_reg <= READY_RST;
      reset_reg  <= RESET_OUT_RST;
    end else if (ce_i) begin
      ready1_reg <= ready1_next;
      ready2_reg <= ready2_next;
      reset_reg  <= reset_next;
    end
  end

  // ==========================================================
  // outputs, all from flops
  assign cpu_clk_o          = dv.cpu_clk;
  assign peripheral_clock_o = dv.periph_clk;
  assign crystal_freq_out_o = osc_reg;
  assign crystal_b_o        = !osc_reg;    // inverting amplifier model
  assign ready_o            = ready2_reg;  // held to next fall
  assign cpu_reset_o        = reset_reg;

  // ==========================================================
  // assertions
  property p_reset_at_fall;
    @(posedge clk_i) disable iff (srst_i)
    $changed(reset_reg) |-> $past(dv.cpu_fall);
  endproperty
  a_reset_at_fall: assert property (p_reset_at_fall)
    else $error("reset output changed away from a falling cpu edge");

  property p_reset_follows;
    @(posedge clk_i) disable iff (srst_i)
    (dv.cpu_fall && !sync_reg[PIN_PORN]) |=> cpu_reset_o;
  endproperty
  a_reset_follows: assert property (p_reset_follows)
    else $error("reset output low while request asserted");

  property p_ready_at_fall;
    @(posedge clk_i) disable iff (srst_i)
    $changed(ready2_reg) |-> $past(dv.cpu_fall);
  endproperty
  a_ready_at_fall: assert property (p_ready_at_fall)
    else $error("ready changed away from a falling cpu edge");

  property p_single_stage;
    @(posedge clk_i) disable iff (srst_i)
    (dv.cpu_fall && sync_reg[PIN_DEPTH]) |=> (ready_o == $past(ready_req));
  endproperty
  a_single_stage: assert property (p_single_stage)
    else $error("single stage ready did not follow request");

  property p_two_stage;
    @(posedge clk_i) disable iff (srst_i)
    (dv.cpu_fall && !sync_reg[PIN_DEPTH] && !ready1_reg) |=> !ready_o;
  endproperty
  a_two_stage: assert property (p_two_stage)
    else $error("two stage ready rose without first stage");

  c_ready_two: cover property (@(posedge clk_i) disable iff (srst_i)
    !sync_reg[PIN_DEPTH] ##1 $rose(ready_o));
  c_ready_one: cover property (@(posedge clk_i) disable iff (srst_i)
    sync_reg[PIN_DEPTH] ##1 $rose(ready_o));
  c_reset_release: cover property (@(posedge clk_i) disable iff (srst_i)
    $fell(cpu_reset_o));
endmodule : cpu_clock_ready_reset_gen
`default_nettype wire

// File: testbench/far_side_model.sv
// far-side model: external frequency source, crystal and clear retiming
// assumes half periods of at least two system clocks, set by the bench
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input  wire logic       clk_i,        // system clock
  input  wire logic [7:0] efi_half_i,   // source half period, clocks
  input  wire logic [7:0] xtal_half_i,  // crystal half period, clocks
  input  wire logic       clear_req_i,  // unaligned clear wish
  output logic            efi_o,        // external frequency source
  output logic            xtal_o,       // crystal level
  output logic            clear_o       // clear, aligned to the source
);
  logic [7:0] efi_cnt;   // source half period counter
  logic [7:0] xtal_cnt;  // crystal half period counter

  initial begin
    efi_o    = 1'b0;
    xtal_o   = 1'b0;
    clear_o  = 1'b0;
    efi_cnt  = 8'h00;
    xtal_cnt = 8'h00;
  end

  // ==========================================================
  // square waves; bench sets three times the wanted cpu rate
  always @(posedge clk_i) begin
    if (efi_cnt + 8'h01 >= efi_half_i) begin
      efi_cnt <= 8'h00;
      efi_o   <= ~efi_o;
    end else begin
      efi_cnt <= efi_cnt + 8'h01;
    end
    if (xtal_cnt + 8'h01 >= xtal_half_i) begin
      xtal_cnt <= 8'h00;
      xtal_o   <= ~xtal_o;
    end else begin
      xtal_cnt <= xtal_cnt + 8'h01;
    end
  end

  // ==========================================================
  // clear only moves as the source falls, like a two-flop retimer
  always @(posedge clk_i) begin
    if (efi_o && (efi_cnt + 8'h01 >= efi_half_i)) begin
      clear_o <= clear_req_i;
    end
  end
endmodule : far_side_model
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the clock, ready and reset generator
// assumes the far-side model supplies source, crystal and clear
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;       // system clock, 100 MHz
  logic        srst;             // synchronous reset
  logic        source_select;    // strap
  logic [7:0]  efi_half;         // source half period
  logic [7:0]  xtal_half;        // crystal half period
  logic        clear_req;        // clear wish to the model
  logic        ext_freq_in;              // source from the model
  logic        xtal;             // crystal from the model
  logic        clear;            // aligned clear from the model
  logic        done1;            // bus one ready
  logic        q1n;              // bus one qualifier
  logic        done2;            // bus two ready
  logic        q2n;              // bus two qualifier
  logic        depth;            // synchroniser depth select
  logic        por_n;            // reset request
  logic        mon_on;           // edge monitor armed
  logic        cpu_prev;         // cpu clock before last edge
  logic        rdy_prev;         // ready before last edge
  logic        rst_prev;         // reset before last edge
  logic        stuck;            // any clock seen high under clear
  logic        ce;               // clock enable to the design
  logic [2:0]  frz;              // levels captured when frozen
  logic [15:0] hi;               // measured high time
  logic [15:0] lo;               // measured low time
  wire         crystal_b_o;
  wire         cpu_clk_o;
  wire         peripheral_clock_o;
  wire         crystal_freq_out_o;
  wire         ready_o;
  wire         cpu_reset_o;
  int          n_fail = 0;       // mismatches
  int          cmp_count = 0;    // comparisons

  always #5 clk = ~clk;

  // ==========================================================
  // parts under test
  far_side_model far_side_model_i (
    .clk_i(clk), .efi_half_i(efi_half), .xtal_half_i(xtal_half),
    .clear_req_i(clear_req), .efi_o(ext_freq_in), .xtal_o(xtal), .clear_o(clear));
  cpu_clock_ready_reset_gen cpu_clock_ready_reset_gen_i (
    .clk_i(clk), .srst_i(srst), .ce_i(ce),
    .source_select_i(source_select), .crystal_a_i(xtal),
    .crystal_b_o(crystal_b_o), .ext_freq_in_i(ext_freq_in), .divider_clear_i(clear),
    .bus1_done_in_i(done1), .bus1_qualifier_n_i(q1n),
    .bus2_done_in_i(done2), .bus2_qualifier_n_i(q2n),
    .sync_depth_select_i(depth), .power_on_request_n_i(por_n),
    .cpu_clk_o(cpu_clk_o), .peripheral_clock_o(peripheral_clock_o),
    .crystal_freq_out_o(crystal_freq_out_o), .ready_o(ready_o),
    .cpu_reset_o(cpu_reset_o));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  function automatic logic pick(input int sel);
    case (sel)
      0:       pick = cpu_clk_o;
      1:       pick = peripheral_clock_o;
      default: pick = crystal_freq_out_o;
    endcase
  endfunction : pick

  // one full period of a chosen output, counted in clocks
  task automatic meas(input int sel);
    int k;
    k  = 0;
    hi = 16'h0000;
    lo = 16'h0000;
    while (pick(sel) !== 1'b0 && k < 200) begin @(negedge clk); k++; end
    while (pick(sel) !== 1'b1 && k < 400) begin @(negedge clk); k++; end
    while (pick(sel) === 1'b1 && k < 600) begin @(negedge clk); hi++; k++; end
    while (pick(sel) === 1'b0 && k < 800) begin @(negedge clk); lo++; k++; end
  endtask : meas

  // bounded wait for a cpu clock edge; lvl 1 rise, 0 fall
  task automatic wait_cpu(input logic lvl);
    int k;
    k = 0;
    do begin @(negedge clk); k++; end
    while (!(cpu_clk_o === lvl && cpu_prev === ~lvl) && k < 100);
    if (k >= 100) chk(16'h0001, 16'h0000);
  endtask : wait_cpu

  // ==========================================================
  // monitor: ready and reset may only move with a cpu fall; levels are
  // taken at falling clk edges, away from the edge that launches them
  always @(negedge clk) begin
    if (mon_on && (ready_o !== rdy_prev || cpu_reset_o !== rst_prev)) begin
      chk({14'h0000, cpu_prev, cpu_clk_o}, 16'h0002);
    end
    cpu_prev <= cpu_clk_o;
    rdy_prev <= ready_o;
    rst_prev <= cpu_reset_o;
  end

  // hang guard, far beyond the expected few thousand cycles
  initial begin
    #200000;
    n_fail++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    srst = 1'b1; source_select = 1'b1; efi_half = 8'h03; xtal_half = 8'h04;
    clear_req = 1'b0; done1 = 1'b0; q1n = 1'b1; done2 = 1'b0; q2n = 1'b1;
    depth = 1'b1; por_n = 1'b0; mon_on = 1'b0; ce = 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(cpu_reset_o, 1'b1);
    chk(ready_o, 1'b0);
    chk({14'h0000, cpu_clk_o, peripheral_clock_o}, 16'h0000);
    chk({14'h0000, crystal_freq_out_o, crystal_b_o}, 16'h0001);
    mon_on = 1'b1;
    // divider from the external source, then the crystal
    meas(0); meas(0);
    chk(hi, 16'h0006);
    chk(lo, 16'h000c);
    meas(1);
    chk(hi, 16'h0012);
    chk(lo, 16'h0012);
    meas(2);
    chk(hi, 16'h0004);
    chk(lo, 16'h0004);
    chk(crystal_b_o, !crystal_freq_out_o);
    // clock enable low freezes the clocks and the oscillator copy
    @(posedge clk) ce <= 1'b0;
    @(negedge clk);
    frz = {cpu_clk_o, peripheral_clock_o, crystal_freq_out_o};
    stuck = 1'b0;
    repeat (30) begin
      @(negedge clk);
      stuck = stuck |
              (frz !== {cpu_clk_o, peripheral_clock_o, crystal_freq_out_o});
    end
    chk(stuck, 1'b0);
    @(posedge clk) ce <= 1'b1;
    @(posedge clk) source_select <= 1'b0; // strap low, crystal source
    meas(0); meas(0);
    chk(hi, 16'h0008);
    chk(lo, 16'h0010);
    @(posedge clk) source_select <= 1'b1;
    meas(0);
    // reset release lands on a cpu fall
    @(posedge clk) por_n <= 1'b1;
    wait_cpu(1'b0); wait_cpu(1'b0);
    chk(cpu_reset_o, 1'b0);
    // divider clear holds both clocks low, then resumes high first
    @(posedge clk) clear_req <= 1'b1;
    repeat (20) @(negedge clk);
    stuck = 1'b0;
    repeat (40) begin
      @(negedge clk);
      stuck = stuck | cpu_clk_o | peripheral_clock_o;
    end
    chk(stuck, 1'b0);
    @(posedge clk) clear_req <= 1'b0;
    wait_cpu(1'b1);
    chk(peripheral_clock_o, 1'b1);
    // every done and qualifier mix in single-stage mode
    for (int i = 0; i < 16; i++) begin
      wait_cpu(1'b0);
      @(posedge clk) {done1, q1n, done2, q2n} <= i[3:0];
      wait_cpu(1'b0); wait_cpu(1'b0);
      chk(ready_o, (i[3] & ~i[2]) | (i[1] & ~i[0]));
    end
    // ready raised just after a cpu rise: one or two stages
    for (int d = 0; d < 2; d++) begin
      @(posedge clk);
      depth <= d[0]; // new depth per loop pass
      done1 <= 1'b0;
      q1n   <= 1'b0;
      done2 <= 1'b0;
      q2n   <= 1'b1;
      wait_cpu(1'b0); wait_cpu(1'b0);
      wait_cpu(1'b1);
      @(posedge clk) done1 <= 1'b1;
      wait_cpu(1'b0);
      chk(ready_o, d[0]);
      wait_cpu(1'b0);
      chk(ready_o, 1'b1);
      wait_cpu(1'b1);
      @(posedge clk) done1 <= 1'b0;
      wait_cpu(1'b0);
      chk(ready_o, 1'b0);
    end
    // reset request again
    @(posedge clk) por_n <= 1'b0;
    wait_cpu(1'b0); wait_cpu(1'b0);
    chk(cpu_reset_o, 1'b1);
    close_out();
  end
endmodule : testbench
`default_nettype wire
